// ==== hw/ctc_pkg.sv ====
// shared types and constants of the processor timing control block
package ctc_pkg;

  // ------------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADR_DCW  = 4'h0; // device_control_word
  localparam logic [3:0] ADR_AUX  = 4'h4; // four_state_read_mode
  localparam logic [3:0] ADR_STAT = 4'h8; // read-only status

  // device_control_word fields
  localparam int DCW_DW_LSB  = 0;  // data wait count, 3 bits
  localparam int DCW_IW_LSB  = 3;  // instruction wait count, 2 bits
  localparam int DCW_HALVE_BIT = 5; // clock_halve_select
  localparam int AUX_FSR_BIT = 0;  // four_state_read_mode
  localparam int STAT_RATE_BIT = 0; // processor clock currently halved
  localparam int STAT_CLK_BIT  = 1; // processor clock level
  localparam int STAT_IW_LSB   = 2; // instruction waits now in force

  // reset values
  localparam logic [1:0] IW_RST  = 2'h3;
  localparam logic [2:0] DW_RST  = 3'h7;
  localparam logic       HALVE_RST = 1'h1;
  localparam logic       FSR_RST = 1'h0;

  // last sys_clk cycle index inside one half state, per rate
  localparam logic SUB_LAST_FULL = 1'h0;
  localparam logic SUB_LAST_HALF = 1'h1;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CTC_TWO, CTC_PC3, CTC_PC4, CTC_PC4W, CTC_DM_WR, CTC_DM_RD
  } ctc_kind_e;

  typedef enum logic [2:0] {
    PH_CLR0, PH_CLR1, PH_FIRST, PH_MID1, PH_MID2, PH_WAIT, PH_FINAL
  } ctc_ph_e;

  typedef enum logic [1:0] {
    RS_DCW, RS_AUX, RS_STAT, RS_NONE
  } ctc_rsel_e;

  // instruction presented by the core at the start of each instruction
  typedef struct packed {
    ctc_kind_e   kind;
    logic [15:0] next_addr;
    logic [15:0] dm_addr;
    logic [7:0]  dm_wdata;
  } ctc_instr_s;

  // external data memory pins
  typedef struct packed {
    logic [7:0] ad;
    logic       ad_oe_n;
    logic [7:0] addr_hi;
    logic       addr_hi_valid;
    logic       ale;
    logic       write_n;
    logic       read_n;
  } ctc_dbus_s;

  typedef struct packed {
    ctc_ph_e     ph;
    logic        half;
    logic        sub;
    logic        osc;
    logic        rate_half;
    logic        parity;
    logic [1:0]  ret_cnt;
    ctc_kind_e   kind;
    logic        rd4;
    logic        second_word;
    logic [2:0]  wleft;
    logic [2:0]  wtarget;
    logic [2:0]  wseen;
    logic        halve_sel;
    logic [1:0]  iw_a;
    logic [1:0]  iw_s;
    logic [2:0]  dw;
    logic        fsr;
    logic        cpu_clk;
    logic        bclk;
    logic [15:0] iaddr;
    ctc_dbus_s   bus;
    logic [15:0] dm_addr;
    logic [7:0]  dm_wdata;
    logic [7:0]  rd_data;
    logic [7:0]  ad_s1;
    logic [7:0]  ad_s2;
    logic        instr_take;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } ctc_state_s;

  localparam ctc_dbus_s BUS_RST = '{ad: 8'h00, ad_oe_n: 1'h0,
    addr_hi: 8'h00, addr_hi_valid: 1'h0, ale: 1'h0, write_n: 1'h1,
    read_n: 1'h1};

  localparam ctc_state_s STATE_RST = '{ph: PH_CLR0, kind: CTC_TWO,
    rate_half: 1'h1, halve_sel: HALVE_RST, iw_a: IW_RST, iw_s: IW_RST,
    dw: DW_RST, fsr: FSR_RST, bus: BUS_RST, iaddr: 16'h0000,
    dm_addr: 16'h0000, wb_dat: 32'h0000_0000, rd_data: 8'h00,
    ad_s1: 8'h00, ad_s2: 8'h00, default: 1'h0};

endpackage

// ==== hw/ctc_top.sv ====
// processor clock, instruction state sequencing and data memory strobes
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns

// Behaviour
// - processor clock runs at oscillator rate, or halved when select bit set
// - reset sets clock_halve_select, processor clock starts halved
// - reset clears processor clock; first crystal rise releases, second raises
// - writing zero switches to full rate at end of that instruction
// - writing one returns to halved one or two states after instruction ends
// - instructions last two to four states: first, intermediates, final
// - boundary clock rises at start, falls half state after address
// - three-state program control: address mid intermediate, clock falls at end
// - data access: boundary clock falls end first; latch strobe one-state pulse, mid first to mid intermediate
// - upper address driven first half to half after final; low byte muxed
// - write: data on bus through final plus half; write strobe in final
// - read: bus floats half after latch falls, driven again at final end
// - four-state read adds second intermediate; read strobe mid that state
// - four-state program control: address mid second intermediate, clock falls
// - two-word four-state instruction runs as two two-state instructions
// - instruction waits from bits four..three, data waits from bits two..zero
// - reset gives three instruction waits, seven data waits, no four-state read
// - instruction wait change: next if program control, else one later
// - all wait states go immediately before the final state
// - data access waits are max of data waits and instruction waits minus one
module ctc_top (
  // clock and reset
  input  logic                sys_clk,
  input  logic                sys_rst,
  // classic wishbone slave
  input  logic                wb_cyc_i,
  input  logic                wb_stb_i,
  input  logic                wb_we_i,
  input  logic [3:0]          wb_adr_i,
  input  logic [3:0]          wb_sel_i,
  input  logic [31:0]         wb_dat_i,
  output logic [31:0]         wb_dat_o,
  output logic                wb_ack_o,
  // core side
  input  ctc_pkg::ctc_instr_s instr,
  output logic                instr_take,
  output logic [7:0]          rd_data,
  // timing and program memory pins
  output logic                cpu_clk,
  output logic                instruction_boundary_clock,
  output logic [15:0]         instruction_address_bus,
  // data memory pins
  input  logic [7:0]          ad_in,
  output ctc_pkg::ctc_dbus_s  dbus
);

  ctc_pkg::ctc_state_s st;
  ctc_pkg::ctc_state_s next_st;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // register decode, shared by the read and the write path
  function automatic ctc_pkg::ctc_rsel_e reg_sel(input logic [3:0] adr);
    ctc_pkg::ctc_rsel_e r;
    unique case (adr)
      ctc_pkg::ADR_DCW:  r = ctc_pkg::RS_DCW;
      ctc_pkg::ADR_AUX:  r = ctc_pkg::RS_AUX;
      ctc_pkg::ADR_STAT: r = ctc_pkg::RS_STAT;
      default:           r = ctc_pkg::RS_NONE;
    endcase
    return r;
  endfunction

  function automatic logic is_data(input ctc_pkg::ctc_kind_e k);
    return (k == ctc_pkg::CTC_DM_WR) || (k == ctc_pkg::CTC_DM_RD);
  endfunction

  // waits of one instruction: program control sees the newest count,
  // other kinds the count snapshotted one instruction earlier
  function automatic logic [2:0] wait_count(input ctc_pkg::ctc_kind_e k,
                                            input logic [1:0] iw_a,
                                            input logic [1:0] iw_s,
                                            input logic [2:0] dw);
    logic [2:0] iwm1;
    iwm1 = (iw_s == 2'h0) ? 3'h0 : {1'h0, iw_s - 2'h1};
    if (is_data(k))
      return (dw > iwm1) ? dw : iwm1;
    else if (k == ctc_pkg::CTC_PC3 || k == ctc_pkg::CTC_PC4)
      return {1'h0, iw_a};
    else
      return {1'h0, iw_s};
  endfunction

  // start of an instruction: processor clock rises, boundary clock rises
  function automatic ctc_pkg::ctc_state_s begin_instr(
      input ctc_pkg::ctc_state_s s, input ctc_pkg::ctc_instr_s ins);
    ctc_pkg::ctc_state_s r;
    ctc_pkg::ctc_kind_e  k;
    r = s;
    k = ins.kind;
    r.second_word = 1'h0;
    if (s.second_word) begin
      k = ctc_pkg::CTC_TWO;
    end else begin
      r.instr_take = 1'h1;
      if (ins.kind == ctc_pkg::CTC_PC4W) begin
        k = ctc_pkg::CTC_TWO;
        r.second_word = 1'h1;
      end
    end
    r.kind     = k;
    r.ph       = ctc_pkg::PH_FIRST;
    r.half     = 1'h0;
    r.cpu_clk  = 1'h1;
    r.bclk     = 1'h1;
    r.rd4      = s.fsr && (k == ctc_pkg::CTC_DM_RD);
    r.wleft    = wait_count(k, s.iw_a, s.iw_s, s.dw);
    r.wtarget  = r.wleft;
    r.wseen    = 3'h0;
    r.iw_s     = s.iw_a;
    r.dm_addr  = ins.dm_addr;
    r.dm_wdata = ins.dm_wdata;
    return r;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // one half state is one sys_clk cycle at full rate, two when halved
  always_comb begin
    logic hs_end;
    logic prog_ia;
    hs_end  = 1'h0;
    prog_ia = 1'h0;
    next_st = st;
    next_st.osc        = ~st.osc;
    next_st.instr_take = 1'h0;
    // data pins are asynchronous to us: two flops before use
    next_st.ad_s1 = ad_in;
    next_st.ad_s2 = st.ad_s1;

    // bus slave: ack one cycle after the request, dropped next cycle
    next_st.wb_ack = wb_cyc_i && wb_stb_i && !st.wb_ack;
    next_st.wb_dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !st.wb_ack) begin
      unique case (reg_sel(wb_adr_i))
        ctc_pkg::RS_DCW: begin
          next_st.wb_dat[ctc_pkg::DCW_DW_LSB +: 3]  = st.dw;
          next_st.wb_dat[ctc_pkg::DCW_IW_LSB +: 2]  = st.iw_a;
          next_st.wb_dat[ctc_pkg::DCW_HALVE_BIT]    = st.halve_sel;
          if (wb_we_i && wb_sel_i[0]) begin
            next_st.dw   = wb_dat_i[ctc_pkg::DCW_DW_LSB +: 3];
            next_st.iw_a = wb_dat_i[ctc_pkg::DCW_IW_LSB +: 2];
            next_st.halve_sel = wb_dat_i[ctc_pkg::DCW_HALVE_BIT];
          end
        end
        ctc_pkg::RS_AUX: begin
          next_st.wb_dat[ctc_pkg::AUX_FSR_BIT] = st.fsr;
          if (wb_we_i && wb_sel_i[0])
            next_st.fsr = wb_dat_i[ctc_pkg::AUX_FSR_BIT];
        end
        ctc_pkg::RS_STAT: begin
          next_st.wb_dat[ctc_pkg::STAT_RATE_BIT]   = st.rate_half;
          next_st.wb_dat[ctc_pkg::STAT_CLK_BIT]    = st.cpu_clk;
          next_st.wb_dat[ctc_pkg::STAT_IW_LSB +: 2] = st.iw_s;
        end
        ctc_pkg::RS_NONE: ; // unmapped: acked, reads zero, write dropped
      endcase
    end

    // halved rate stretches every half state to two cycles
    hs_end = (st.sub == (st.rate_half ? ctc_pkg::SUB_LAST_HALF
                                      : ctc_pkg::SUB_LAST_FULL));
    next_st.sub = hs_end ? 1'h0 : 1'h1;

    unique case (st.ph)
      // processor clock held low; released on crystal rising edges
      ctc_pkg::PH_CLR0: begin
        next_st.sub = 1'h0;
        if (!st.osc)
          next_st.ph = ctc_pkg::PH_CLR1;
      end
      ctc_pkg::PH_CLR1: begin
        next_st.sub = 1'h0;
        if (!st.osc)
          next_st = begin_instr(next_st, instr);
      end
      default: begin
        if (hs_end && !st.half) begin
          // falling processor clock edge: mid-state events
          next_st.half    = 1'h1;
          next_st.cpu_clk = 1'h0;
          prog_ia = (st.ph == ctc_pkg::PH_FIRST &&
                     (st.kind == ctc_pkg::CTC_TWO || is_data(st.kind)))
                 || (st.ph == ctc_pkg::PH_MID1 &&
                     st.kind == ctc_pkg::CTC_PC3)
                 || (st.ph == ctc_pkg::PH_MID2 &&
                     st.kind == ctc_pkg::CTC_PC4);
          if (prog_ia)
            next_st.iaddr = instr.next_addr;
          if (st.ph == ctc_pkg::PH_FIRST) begin
            // previous data access ends half a state after its final
            next_st.bus.addr_hi_valid = 1'h0;
            if (is_data(st.kind)) begin
              next_st.bus.ale           = 1'h1;
              next_st.bus.addr_hi       = st.dm_addr[15:8];
              next_st.bus.addr_hi_valid = 1'h1;
              next_st.bus.ad            = st.dm_addr[7:0];
              next_st.bus.ad_oe_n       = 1'h0;
            end
          end
          if (st.ph == ctc_pkg::PH_MID1 && is_data(st.kind))
            next_st.bus.ale = 1'h0;
          if (st.ph == ctc_pkg::PH_MID2 && st.rd4)
            next_st.bus.read_n = 1'h0;
        end else if (hs_end) begin
          // rising processor clock edge: the state ends
          next_st.half    = 1'h0;
          next_st.cpu_clk = 1'h1;
          unique case (st.ph)
            ctc_pkg::PH_FIRST: begin
              if (st.kind == ctc_pkg::CTC_TWO || is_data(st.kind))
                next_st.bclk = 1'h0;
              next_st.ph = (st.kind == ctc_pkg::CTC_TWO)
                ? ((st.wleft != 3'h0) ? ctc_pkg::PH_WAIT
                                      : ctc_pkg::PH_FINAL)
                : ctc_pkg::PH_MID1;
            end
            ctc_pkg::PH_MID1: begin
              if (st.kind == ctc_pkg::CTC_PC3)
                next_st.bclk = 1'h0;
              if (st.kind == ctc_pkg::CTC_DM_RD)
                next_st.bus.ad_oe_n = 1'h1;
              if (st.kind == ctc_pkg::CTC_PC4 || st.rd4)
                next_st.ph = ctc_pkg::PH_MID2;
              else
                next_st.ph = (st.wleft != 3'h0) ? ctc_pkg::PH_WAIT
                                                : ctc_pkg::PH_FINAL;
            end
            ctc_pkg::PH_MID2: begin
              if (st.kind == ctc_pkg::CTC_PC4)
                next_st.bclk = 1'h0;
              next_st.ph = (st.wleft != 3'h0) ? ctc_pkg::PH_WAIT
                                              : ctc_pkg::PH_FINAL;
            end
            ctc_pkg::PH_WAIT: begin
              next_st.wleft = st.wleft - 3'h1;
              next_st.wseen = st.wseen + 3'h1;
              if (st.wleft == 3'h1)
                next_st.ph = ctc_pkg::PH_FINAL;
            end
            ctc_pkg::PH_FINAL: begin
              next_st.bus.write_n = 1'h1;
              next_st.bus.read_n  = 1'h1;
              if (st.kind == ctc_pkg::CTC_DM_RD) begin
                next_st.rd_data     = st.ad_s2;
                next_st.bus.ad_oe_n = 1'h0;
              end
              next_st = begin_instr(next_st, instr);
            end
            default: next_st.ph = ctc_pkg::PH_CLR0;
          endcase
          // strobes cover wait states and the final state
          if (is_data(st.kind) && st.ph != ctc_pkg::PH_WAIT &&
              st.ph != ctc_pkg::PH_FINAL &&
              (next_st.ph == ctc_pkg::PH_WAIT ||
               next_st.ph == ctc_pkg::PH_FINAL)) begin
            if (st.kind == ctc_pkg::CTC_DM_WR)
              next_st.bus.write_n = 1'h0;
            else
              next_st.bus.read_n = 1'h0;
          end
          if (st.kind == ctc_pkg::CTC_DM_WR &&
              next_st.ph == ctc_pkg::PH_FINAL)
            next_st.bus.ad = st.dm_wdata;
          // rate changes happen only at state boundaries, clock rising
          if (!st.rate_half)
            next_st.parity = ~st.parity;
          if (st.ph == ctc_pkg::PH_FINAL && !st.halve_sel &&
              st.rate_half) begin
            next_st.rate_half = 1'h0;
            next_st.parity    = 1'h0;
          end else if (st.ret_cnt != 2'h0) begin
            next_st.ret_cnt = st.ret_cnt - 2'h1;
            if (st.ret_cnt == 2'h1)
              next_st.rate_half = 1'h1;
          end else if (st.ph == ctc_pkg::PH_FINAL && st.halve_sel &&
                       !st.rate_half) begin
            // even state count since the switch costs one more state
            next_st.ret_cnt = st.parity ? 2'h1 : 2'h2;
          end
        end
      end
    endcase
  end

  // state register; reset clears the processor clock at once
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      st <= ctc_pkg::STATE_RST;
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign wb_dat_o                   = st.wb_dat;
  assign wb_ack_o                   = st.wb_ack;
  assign instr_take                 = st.instr_take;
  assign rd_data                    = st.rd_data;
  assign cpu_clk                    = st.cpu_clk;
  assign instruction_boundary_clock = st.bclk;
  assign instruction_address_bus    = st.iaddr;
  assign dbus                       = st.bus;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_state_rise;
    $rose(st.cpu_clk);
  endsequence
  sequence s_half_state_low;
    !st.cpu_clk ##1 !st.cpu_clk;
  endsequence

  a_halved_period: assert property (
    s_state_rise and st.rate_half |-> st.cpu_clk ##1 st.cpu_clk
      ##1 s_half_state_low)
    else $error("halved processor clock period wrong");
  a_full_period: assert property (
    s_state_rise and !st.rate_half |=> !st.cpu_clk)
    else $error("full rate processor clock period wrong");
  a_reset_halved: assert property (
    st.ph == ctc_pkg::PH_CLR1 |-> st.halve_sel && st.rate_half &&
      st.iw_a == ctc_pkg::IW_RST)
    else $error("reset did not select halved clock");
  a_clear_release: assert property (
    st.ph == ctc_pkg::PH_CLR1 && !st.osc |=>
      st.cpu_clk && st.ph == ctc_pkg::PH_FIRST)
    else $error("processor clock not raised after clear");
  a_full_switch_end: assert property (
    $fell(st.rate_half) |-> st.ph == ctc_pkg::PH_FIRST &&
      $past(st.ph) == ctc_pkg::PH_FINAL)
    else $error("full rate switch away from instruction end");
  a_instruction_boundary_clock_start: assert property (
    $rose(st.bclk) |-> st.ph == ctc_pkg::PH_FIRST && !st.half)
    else $error("boundary clock rose off instruction start");
  a_latch_window: assert property (
    $fell(st.bus.ale) |-> st.ph == ctc_pkg::PH_MID1 && st.half &&
      st.bus.addr_hi_valid)
    else $error("latch strobe fell at wrong point");
  a_write_final: assert property (
    $fell(st.bus.write_n) ##0 (st.ph == ctc_pkg::PH_FINAL) |->
      !st.half && st.bus.ad == st.dm_wdata && !st.bus.ad_oe_n)
    else $error("write strobe without data on bus");
  a_read_four_state: assert property (
    $fell(st.bus.read_n) && st.rd4 |-> st.ph == ctc_pkg::PH_MID2 &&
      st.half && st.bus.ad_oe_n)
    else $error("four-state read strobe at wrong point");
  a_data_waits: assert property (
    st.ph == ctc_pkg::PH_FINAL && $past(st.ph) != ctc_pkg::PH_FINAL &&
      is_data(st.kind) |-> st.wseen == st.wtarget)
    else $error("data access wait count wrong");
  // the latch strobe must never show a floating or stale upper byte
  a_latch_addr_valid: assert property (
    st.bus.ale |-> st.bus.addr_hi_valid && !st.bus.ad_oe_n)
    else $error("latch strobe without address driven");
  a_read_floats: assert property (
    !st.bus.read_n |-> st.bus.ad_oe_n)
    else $error("read strobe while bus still driven");
  a_write_strobe_end: assert property (
    $rose(st.bus.write_n) |-> st.ph == ctc_pkg::PH_FIRST && !st.half)
    else $error("write strobe ended off the final state end");
  a_halve_return: assert property (
    $rose(st.rate_half) |-> st.cpu_clk && !st.half)
    else $error("halved rate resumed off a state boundary");

endmodule // ctc_top

// ==== testbench/ctc_mem_model.sv ====
// behavioural external data memory on the multiplexed address/data bus
`timescale 1ns/1ns
module ctc_mem_model (
  // clock
  input  logic               sys_clk,
  // data memory pins
  input  ctc_pkg::ctc_dbus_s dbus,
  output logic [7:0]         ad_in
);
  logic [7:0]  mem [16];
  logic [15:0] lat   = 16'h0000;
  logic        ale_q = 1'h0;
  logic [7:0]  drv   = 8'h00;

  // -------------------------------------------------------------------
  // address latch and storage
  // -------------------------------------------------------------------
  // low byte taken when the latch strobe falls, like an external latch
  always_ff @(posedge sys_clk) begin
    ale_q <= dbus.ale;
    if (ale_q && !dbus.ale) lat <= {dbus.addr_hi, dbus.ad};
    if (!dbus.write_n) mem[lat[3:0]] <= dbus.ad; // last strobe cycle wins
  end

  // released bus toggles, so a stale value can never pass for read data
  always_ff @(posedge sys_clk) begin
    if (!dbus.read_n) drv <= mem[lat[3:0]];
    else drv <= ~drv;
  end
  assign ad_in = drv;
endmodule // ctc_mem_model

// ==== testbench/cpu_timing_control_tb.sv ====
// self-checking bench: registers and instruction timing of the control block
`timescale 1ns/1ns
module cpu_timing_control_tb;
  logic                sys_clk  = 1'h0;
  logic                sys_rst  = 1'h1;
  logic                wb_cyc_i = 1'h0;
  logic                wb_stb_i = 1'h0;
  logic                wb_we_i  = 1'h0;
  logic [3:0]          wb_adr_i = 4'h0;
  logic [3:0]          wb_sel_i = 4'hF;
  logic [31:0]         wb_dat_i = 32'h0000_0000;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  ctc_pkg::ctc_instr_s instr    = '0;
  logic                instr_take;
  logic [7:0]          rd_data;
  logic                cpu_clk;
  logic                bclk;
  logic [15:0]         iaddr;
  logic [7:0]          ad_in;
  ctc_pkg::ctc_dbus_s  dbus;
  logic [31:0]         rd32;
  logic [7:0]          wd;
  logic [15:0]         na_v     = 16'h1000;
  int                  failures = 0;
  int                  compares = 0;
  int                  n_cyc, n_wr, n_rd, n_ale, n;

  // 20 MHz timing base
  always #25 sys_clk = ~sys_clk;

  ctc_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr(instr), .instr_take(instr_take),
    .rd_data(rd_data), .cpu_clk(cpu_clk),
    .instruction_boundary_clock(bclk), .instruction_address_bus(iaddr),
    .ad_in(ad_in), .dbus(dbus));
  ctc_mem_model i_mem (.sys_clk(sys_clk), .dbus(dbus), .ad_in(ad_in));

  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic close_out();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] dat);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n >= 50) failures++;
    if (n >= 50) close_out();
    rd32 = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  // runs to the next instruction start, counting strobe cycles meanwhile
  task automatic take_wait();
    n_cyc = 0;
    n_wr  = 0;
    n_rd  = 0;
    n_ale = 0;
    do begin
      @(posedge sys_clk);
      n_cyc++;
      if (dbus.write_n === 1'h0) wd = dbus.ad;
      n_wr  += (dbus.write_n === 1'h0) ? 1 : 0;
      n_rd  += (dbus.read_n === 1'h0) ? 1 : 0;
      n_ale += (dbus.ale === 1'h1) ? 1 : 0;
    end while (instr_take !== 1'h1 && n_cyc < 400);
    if (n_cyc >= 400) failures++;
    if (n_cyc >= 400) close_out();
  endtask

  // set registers, issue one kind and time the instruction that takes it
  task automatic step(input logic [7:0] dcw, input logic fsr,
                      input ctc_pkg::ctc_kind_e k, input int states,
                      input int wl, input int rl);
    int st;
    st = dcw[ctc_pkg::DCW_HALVE_BIT] ? 4 : 2;
    na_v = na_v + 16'h0101;
    wb(1'h1, ctc_pkg::ADR_DCW, {24'h000000, dcw});
    wb(1'h1, ctc_pkg::ADR_AUX, {31'h00000000, fsr});
    take_wait();
    instr <= '{kind: k, next_addr: na_v, dm_addr: 16'h0003, dm_wdata: 8'h5A};
    take_wait();
    take_wait();
    chk(32'(n_cyc), 32'(states * st), "instruction length");
    chk(32'(n_wr), 32'(wl), "write strobe cycles");
    chk(32'(n_rd), 32'(rl), "read strobe cycles");
    chk(32'(n_ale), (wl + rl > 0) ? 32'(st) : 32'h0, "latch strobe");
    chk({16'h0000, iaddr}, {16'h0000, na_v}, "next address");
    chk({31'h0, bclk}, 32'h1, "boundary clock at start");
    chk({31'h0, cpu_clk}, 32'h1, "processor clock at start");
    if (wl > 0) chk({24'h0, wd}, 32'h5A, "write data");
    if (rl > 0) chk({24'h0, rd_data}, 32'h5A, "read data");
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cpu_clk !== 1'h1 && n < 20);
    chk(32'(n >= 3 && n <= 5), 32'h1, "first clock rise");
    wb(1'h0, ctc_pkg::ADR_DCW, 32'h0);
    chk(rd32, 32'h0000_003F, "control word reset");
    wb(1'h0, ctc_pkg::ADR_AUX, 32'h0);
    chk(rd32, 32'h0000_0000, "read mode reset");
    wb(1'h0, ctc_pkg::ADR_STAT, 32'h0);
    chk(rd32 & 32'h0000_000D, 32'h0000_000D, "status reset");
    wb(1'h1, 4'hC, 32'h0000_00FF);
    wb(1'h0, 4'hC, 32'h0);
    chk(rd32, 32'h0000_0000, "unmapped read");
    step(8'h3F, 1'h0, ctc_pkg::CTC_TWO, 5, 0, 0);
    wb(1'h0, ctc_pkg::ADR_DCW, 32'h0);
    chk(rd32, 32'h0000_003F, "control word readback");
    step(8'h20, 1'h0, ctc_pkg::CTC_TWO, 2, 0, 0);
    step(8'h20, 1'h0, ctc_pkg::CTC_PC3, 3, 0, 0);
    step(8'h28, 1'h0, ctc_pkg::CTC_PC3, 4, 0, 0);
    step(8'h20, 1'h0, ctc_pkg::CTC_PC4, 4, 0, 0);
    step(8'h20, 1'h0, ctc_pkg::CTC_PC4W, 4, 0, 0);
    step(8'h20, 1'h0, ctc_pkg::CTC_DM_WR, 3, 4, 0);
    step(8'h20, 1'h0, ctc_pkg::CTC_DM_RD, 3, 0, 4);
    step(8'h22, 1'h0, ctc_pkg::CTC_DM_WR, 5, 12, 0);
    step(8'h38, 1'h0, ctc_pkg::CTC_DM_WR, 5, 12, 0);
    step(8'h20, 1'h1, ctc_pkg::CTC_DM_RD, 4, 0, 6);
    step(8'h00, 1'h0, ctc_pkg::CTC_TWO, 2, 0, 0);
    wb(1'h0, ctc_pkg::ADR_STAT, 32'h0);
    chk(rd32 & 32'h0000_0001, 32'h0, "full rate in force");
    // the return to halved rate may land inside the next two instructions
    wb(1'h1, ctc_pkg::ADR_DCW, 32'h0000_0020);
    take_wait();
    take_wait();
    step(8'h20, 1'h0, ctc_pkg::CTC_TWO, 2, 0, 0);
    wb(1'h0, ctc_pkg::ADR_STAT, 32'h0);
    chk(rd32 & 32'h0000_0001, 32'h1, "halved rate back");
    close_out();
  end
endmodule // cpu_timing_control_tb
